/* csc_pkg.sv */
/*
 * package for the chiller sequence controller: temperature codes, timing constants,
 * mode encoding and the carrier structs shared by the controller and its helpers.
 * assumes temperatures arrive as signed whole degrees C, one code per degree.
 */
package csc_pkg;

	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned TEMP_W          = 8;
	localparam int unsigned TMR_W           = 9;

	// thermostat defaults, signed degrees C
	localparam logic signed [7:0] COOL_SET_C     = 8'sh0c;   // 12
	localparam logic signed [7:0] COOL_HYST_C    = 8'sh03;   // 3
	localparam logic signed [7:0] HEAT_SET_C     = 8'sh28;   // 40
	localparam logic signed [7:0] HEAT_HYST_C    = 8'sh04;   // 4
	localparam logic signed [7:0] FROST_TRIP_C   = 8'sh03;   // 3
	localparam logic signed [7:0] FROST_CLEAR_C  = 8'sh0f;   // 15
	localparam logic signed [7:0] COND_TRIP_C    = 8'sh3e;   // 62
	localparam logic signed [7:0] COND_CLEAR_C   = 8'sh34;   // 52

	// times in seconds, counted on the one second tick
	localparam logic [TMR_W-1:0] RESTART_S       = 9'h12c;   // 300
	localparam logic [TMR_W-1:0] PUMP_LEAD_S     = 9'h11d;   // 285
	localparam logic [TMR_W-1:0] PUMP_TRAIL_S    = 9'h078;   // 120
	localparam logic [TMR_W-1:0] FLOW_MASK_S     = 9'h078;   // 120
	localparam logic [TMR_W-1:0] FLOW_CLEAR_S    = 9'h00f;   // 15

	localparam int unsigned TICK_W           = 26;

	typedef enum logic {CSC_COOL, CSC_HEAT} csc_mode_type;

	// switch and sensor bundle presented to the controller
	typedef struct packed {
		logic remote_shutdown;   // closed contact = forced stop
		logic remote_mode;       // closed = heat, open = cool
		logic flow_fault;        // flow or differential pressure switch tripped
		logic overcurrent;
	} csc_contacts_type;

	typedef struct packed {
		logic signed [TEMP_W-1:0] water;
		logic signed [TEMP_W-1:0] outlet;
		logic signed [TEMP_W-1:0] condenser;
	} csc_temps_type;

	typedef struct packed {
		logic frost;
		logic flow;
		logic cond_hot;
	} csc_alarms_type;

endpackage

/* csc_sync.sv */
/*
 * two flip-flop synchroniser for a vector of contact inputs.
 * assumes the inputs are asynchronous levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module csc_sync
	import csc_pkg::*;
#(
	parameter int unsigned W = 4
) (
	input  wire logic         clk_i,   // system clock
	input  wire logic         rst_n_i, // async reset, low
	input  wire logic [W-1:0] d_i,     // raw pins
	output logic      [W-1:0] q_o      // synchronised levels
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// plain shift by one stage
	always_comb begin
		next_meta = d_i;
		next_q    = meta;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= next_meta;
			q_o  <= next_q;
		end
	end
endmodule

/* csc_tick.sv */
/*
 * one second tick generator: a single pulse per second from the system clock.
 * assumes clk_i runs at CLK_HZ; the divider is a parameter so simulation can shorten it.
 */
`timescale 1ns/1ps
module csc_tick
	import csc_pkg::*;
#(
	parameter int unsigned DIV = CLK_HZ
) (
	input  wire logic clk_i,   // system clock
	input  wire logic rst_n_i, // async reset, low
	output logic      tick_o   // one cycle pulse per second
);
	logic [TICK_W-1:0] cnt;
	logic [TICK_W-1:0] next_cnt;
	logic              next_tick;

	localparam logic [TICK_W-1:0] LAST = TICK_W'(DIV - 1);

	// wrap at the divider and flag the wrap
	always_comb begin
		next_tick = (cnt == LAST);
		next_cnt  = next_tick ? '0 : cnt + 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule

/* csc_ctrl.sv */
/*
 * chiller sequence controller: command arbitration, thermostat with hysteresis,
 * compressor restart guard, pump sequencing and the frost, flow and condenser alarms.
 * assumes temperatures come from same-clock logic as signed degrees; contacts are raw pins.
 * the stored mode is kept by an always-on domain outside: saved_mode_i is read at reset release.
 */
// Behaviour
// - remote mode contact closed forces heating mode
// - remote mode contact open forces cooling mode
// - remote inputs honoured only when the function select switch enables them
// - factory default leaves remote function disabled until the switch changes
// - latest command from remote or wired controller wins
// - remote shutdown overrides every start request
// - with wired controller connected, panel mode and set point writes are refused
// - cooling: compressor requested above 12 C
// - cooling: request removed below 9 C, held off until restart threshold
// - heating: compressor requested below 38 C
// - heating: request removed above 42 C, held off until restart threshold
// - selected mode stored so it survives power loss
// - at least 300 s between compressor starts
// - pump on at power-up, running 285 s before compressor start
// - pump runs on 120 s after shutdown then stops
// - flow alarm masked for first 120 s of pump operation
// - fan follows pressure probe regardless of compressor
// - outlet below 3 C raises frost alarm and stops compressor
// - frost or flow alarm keeps compressor off, pump on
// - frost alarm cleared by manual reset only above 15 C
// - flow alarm clears after contact released 15 s continuously
// - overcurrent with condenser above 62 C shuts down until below 52 C
// - remote shutdown stops unit, protections stay active
`timescale 1ns/1ps
module csc_ctrl
	import csc_pkg::*;
#(
	parameter int unsigned TICK_DIV = CLK_HZ
) (
	input  wire logic                  clk_i,            // 40 MHz system clock
	input  wire logic                  rst_n_i,          // async reset, low
	input  wire logic                  remote_function_select_switch_i, // enables remote contacts
	input  wire logic                  remote_shutdown_i, // raw contact, high = closed
	input  wire logic                  remote_mode_i,    // raw contact, high = closed
	input  wire logic                  flow_fault_i,     // raw flow switch, high = tripped
	input  wire logic                  overcurrent_i,    // raw overcurrent flag
	input  wire logic                  wired_present_i,  // wired controller connected
	input  wire logic                  wired_cmd_i,      // one cycle: wired command strobe
	input  wire logic                  wired_run_i,      // wired: run request
	input  wire logic                  wired_mode_i,     // wired: 1 heat, 0 cool
	input  wire logic                  panel_cmd_i,      // one cycle: panel command strobe
	input  wire logic                  panel_run_i,      // panel: run request
	input  wire logic                  panel_mode_i,     // panel: 1 heat, 0 cool
	input  wire logic                  saved_mode_i,     // stored mode from retained memory
	input  wire logic                  frost_reset_i,    // manual frost reset, one cycle
	input  wire logic signed [TEMP_W-1:0] water_temp_i,  // inlet water, degrees
	input  wire logic signed [TEMP_W-1:0] outlet_temp_i, // exchanger outlet, degrees
	input  wire logic signed [TEMP_W-1:0] cond_temp_i,   // condenser, degrees
	input  wire logic [7:0]            fan_pressure_i,   // pressure probe reading
	output logic                       compressor_o,     // compressor enable
	output logic                       pump_o,           // pump enable
	output logic [7:0]                 fan_speed_o,      // fan speed demand
	output logic                       mode_heat_o,      // effective mode, 1 heat
	output logic                       save_mode_o,      // mode to retain
	output logic                       panel_refused_o,  // panel write rejected, pulse
	output logic                       frost_alarm_o,    // frost alarm
	output logic                       flow_alarm_o,     // water flow alarm
	output logic                       cond_alarm_o      // condenser overtemp alarm
);
	logic             tick;
	logic [4:0]       sync_q;
	csc_contacts_type ct;
	csc_temps_type    tp;

	csc_tick #(.DIV(TICK_DIV)) u_tick (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.tick_o (tick)
	);

	// pins, the function select switch too, cross into the clock domain before use
	csc_sync #(.W(5)) u_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    ({remote_function_select_switch_i, remote_shutdown_i, remote_mode_i, flow_fault_i, overcurrent_i}),
		.q_o    (sync_q)
	);

	assign ct = csc_contacts_type'(sync_q[3:0]);
	assign tp = '{water: water_temp_i, outlet: outlet_temp_i, condenser: cond_temp_i};

	// saturating seconds counter step
	function automatic logic [TMR_W-1:0] sec_step(input logic [TMR_W-1:0] v, input logic t,
		input logic [TMR_W-1:0] lim);
		sec_step = (t && v < lim) ? v + 1'b1 : v;
	endfunction

	// ---------------- command arbitration ----------------
	logic         run_req, next_run_req;
	csc_mode_type mode, next_mode;
	logic         rmode_d, next_rmode_d;
	logic         remote_on;
	logic         loaded, next_loaded;

	assign remote_on = sync_q[4];

	// most recent command wins; a change of the remote mode contact counts as a command
	always_comb begin
		next_run_req    = run_req;
		next_mode       = mode;
		next_rmode_d    = ct.remote_mode;
		next_loaded     = 1'b1;
		panel_refused_o = 1'b0;
		if (!loaded) begin
			next_mode = csc_mode_type'(saved_mode_i);
		end
		if (panel_cmd_i) begin
			if (wired_present_i) begin
				panel_refused_o = 1'b1;
			end else begin
				next_run_req = panel_run_i;
				next_mode    = csc_mode_type'(panel_mode_i);
			end
		end
		if (wired_cmd_i && wired_present_i) begin
			next_run_req = wired_run_i;
			next_mode    = csc_mode_type'(wired_mode_i);
		end
		if (remote_on && loaded && (ct.remote_mode != rmode_d)) begin
			next_mode = ct.remote_mode ? CSC_HEAT : CSC_COOL;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_req <= 1'b0;
			mode    <= CSC_COOL;
			rmode_d <= 1'b0;
			loaded  <= 1'b0;
		end else begin
			run_req <= next_run_req;
			mode    <= next_mode;
			rmode_d <= next_rmode_d;
			loaded  <= next_loaded;
		end
	end

	assign mode_heat_o = (mode == CSC_HEAT);
	assign save_mode_o = mode_heat_o;

	logic shut_remote;
	assign shut_remote = remote_on && ct.remote_shutdown;

	// ---------------- thermostat ----------------
	logic demand, next_demand;

	// hysteresis band; demand holds between the two thresholds
	always_comb begin
		next_demand = demand;
		if (mode == CSC_COOL) begin
			if (tp.water > COOL_SET_C)
				next_demand = 1'b1;
			else if (tp.water < COOL_SET_C - COOL_HYST_C)
				next_demand = 1'b0;
		end else begin
			if (tp.water < HEAT_SET_C - (HEAT_HYST_C >>> 1))
				next_demand = 1'b1;
			else if (tp.water > HEAT_SET_C + (HEAT_HYST_C >>> 1))
				next_demand = 1'b0;
		end
	end

	// ---------------- alarms ----------------
	csc_alarms_type alm, next_alm;
	logic [TMR_W-1:0] flow_ok_s, next_flow_ok_s;
	logic             flow_armed;                // flow alarm detection live

	// set wins over any clear in the same cycle; protections run even in remote shutdown
	always_comb begin
		next_alm       = alm;
		next_flow_ok_s = ct.flow_fault ? '0 : sec_step(flow_ok_s, tick, FLOW_CLEAR_S);
		if (frost_reset_i && tp.outlet > FROST_CLEAR_C)
			next_alm.frost = 1'b0;
		if (tp.outlet < FROST_TRIP_C)
			next_alm.frost = 1'b1;
		if (flow_ok_s >= FLOW_CLEAR_S)
			next_alm.flow = 1'b0;
		if (ct.flow_fault && flow_armed)
			next_alm.flow = 1'b1;
		if (tp.condenser < COND_CLEAR_C)
			next_alm.cond_hot = 1'b0;
		if (ct.overcurrent && tp.condenser > COND_TRIP_C)
			next_alm.cond_hot = 1'b1;
	end

	// ---------------- sequencing ----------------
	logic [TMR_W-1:0] pump_s, next_pump_s;       // seconds of pump run
	logic [TMR_W-1:0] since_start, next_since_start;
	logic [TMR_W-1:0] trail_s, next_trail_s;
	logic             pump, next_pump;
	logic             comp, next_comp;
	logic             unit_on, allow;

	assign flow_armed = pump && (pump_s >= FLOW_MASK_S);
	assign unit_on    = run_req && !shut_remote && !alm.cond_hot;
	assign allow      = unit_on && !alm.frost && !alm.flow && demand;

	// pump leads the compressor and runs on after shutdown; all timers on one tick
	always_comb begin
		next_trail_s     = unit_on ? '0 : sec_step(trail_s, tick, PUMP_TRAIL_S);
		next_pump        = unit_on || alm.frost || alm.flow
			|| (trail_s < PUMP_TRAIL_S);
		next_pump_s      = pump ? sec_step(pump_s, tick, PUMP_LEAD_S) : '0;
		next_since_start = sec_step(since_start, tick, RESTART_S);
		next_comp        = comp && allow;
		if (!comp && allow && pump && pump_s >= PUMP_LEAD_S
			&& since_start >= RESTART_S) begin
			next_comp        = 1'b1;
			next_since_start = '0;
		end
	end

	// trail counter starts cleared so the pump runs from power-up
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			demand      <= 1'b0;
			alm         <= '0;
			flow_ok_s   <= '0;
			pump_s      <= '0;
			since_start <= RESTART_S;
			trail_s     <= '0;
			pump        <= 1'b1;
			comp        <= 1'b0;
		end else begin
			demand      <= next_demand;
			alm         <= next_alm;
			flow_ok_s   <= next_flow_ok_s;
			pump_s      <= next_pump_s;
			since_start <= next_since_start;
			trail_s     <= next_trail_s;
			pump        <= next_pump;
			comp        <= next_comp;
		end
	end

	// fan tracks the probe only; compressor state deliberately not consulted
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			fan_speed_o <= '0;
		else
			fan_speed_o <= fan_pressure_i;
	end

	assign compressor_o  = comp;
	assign pump_o        = pump;
	assign frost_alarm_o = alm.frost;
	assign flow_alarm_o  = alm.flow;
	assign cond_alarm_o  = alm.cond_hot;

	// ---------------- assertions ----------------
	sequence s_start;
		!comp ##1 comp;
	endsequence

	property p_no_start_in_shutdown;
		@(posedge clk_i) disable iff (!rst_n_i) shut_remote |=> !$rose(comp);
	endproperty
	a_no_start_in_shutdown: assert property (p_no_start_in_shutdown)
		else $error("compressor started during remote shutdown");

	property p_restart_gap;
		@(posedge clk_i) disable iff (!rst_n_i) s_start |-> $past(since_start, 1) >= RESTART_S;
	endproperty
	a_restart_gap: assert property (p_restart_gap)
		else $error("compressor restarted too soon");

	property p_pump_lead;
		@(posedge clk_i) disable iff (!rst_n_i) s_start |-> $past(pump_s, 1) >= PUMP_LEAD_S && pump;
	endproperty
	a_pump_lead: assert property (p_pump_lead)
		else $error("compressor started before pump lead time");

	property p_alarm_blocks;
		@(posedge clk_i) disable iff (!rst_n_i) (alm.frost || alm.flow) |=> !comp && pump;
	endproperty
	a_alarm_blocks: assert property (p_alarm_blocks)
		else $error("alarm did not stop compressor or keep pump");

	property p_frost_trip;
		@(posedge clk_i) disable iff (!rst_n_i) tp.outlet < FROST_TRIP_C |=> alm.frost ##1 !comp;
	endproperty
	a_frost_trip: assert property (p_frost_trip)
		else $error("frost alarm missed");

	property p_frost_hold;
		@(posedge clk_i) disable iff (!rst_n_i) alm.frost && !frost_reset_i |=> alm.frost;
	endproperty
	a_frost_hold: assert property (p_frost_hold)
		else $error("frost alarm cleared without manual reset");

	property p_cool_on;
		@(posedge clk_i) disable iff (!rst_n_i) mode == CSC_COOL && tp.water > COOL_SET_C |=> demand;
	endproperty
	a_cool_on: assert property (p_cool_on)
		else $error("cooling demand not raised above set point");

	property p_heat_off;
		@(posedge clk_i) disable iff (!rst_n_i)
			mode == CSC_HEAT && tp.water > HEAT_SET_C + (HEAT_HYST_C >>> 1) |=> !demand;
	endproperty
	a_heat_off: assert property (p_heat_off)
		else $error("heating demand not removed above upper threshold");

	property p_panel_refused;
		@(posedge clk_i) disable iff (!rst_n_i)
			panel_cmd_i && wired_present_i && !wired_cmd_i && !(remote_on && ct.remote_mode != rmode_d)
			|=> mode == $past(mode, 1);
	endproperty
	a_panel_refused: assert property (p_panel_refused)
		else $error("panel changed mode while wired controller present");

	property p_cond_trip;
		@(posedge clk_i) disable iff (!rst_n_i)
			ct.overcurrent && tp.condenser > COND_TRIP_C |=> alm.cond_hot ##1 !comp;
	endproperty
	a_cond_trip: assert property (p_cond_trip)
		else $error("condenser protection missed");
endmodule

/* csc_plant.sv */
/*
 * far-side model: contact switches and temperature sensors of the chiller.
 * assumes the bench sets the wanted levels at a clock edge; the model presents them one cycle later.
 */
`timescale 1ns/1ps
module csc_plant
	import csc_pkg::*;
(
	input  wire logic             clk_i,    // system clock
	input  wire csc_contacts_type want_c_i, // contact levels wanted by the bench
	input  wire csc_temps_type    want_t_i, // sensor readings wanted by the bench
	output csc_contacts_type      c_o,      // contact pins
	output csc_temps_type         t_o       // sensor codes
);
	// contacts are plain levels that never float, so a one cycle copy is enough
	always_ff @(posedge clk_i) begin
		c_o <= want_c_i;
		t_o <= want_t_i;
	end
endmodule

/* test_chiller_sequence_controller.sv */
/*
 * self-checking bench for the chiller sequence controller.
 * assumes a shortened second tick of 4 cycles; contact pins and temperature sensors come from csc_plant.
 */
`timescale 1ns/1ps
`define CHK(g, e, m) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("wrong value at %0t: %s", $time, m); \
	end \
end
module test_chiller_sequence_controller;
	import csc_pkg::*;
	typedef struct packed {
		logic pres, wcmd, wmode, pcmd, pmode;
		logic [7:0] fan;
		logic heat, refused;
	} csc_row_type;
	logic clk_i, rst_n_i, sel, wpres, wcmd, wrun, wmode, pcmd, prun, pmode, saved, frst;
	logic [7:0] fan;
	csc_contacts_type want_c, pin_c;
	csc_temps_type want_t, pin_t;
	logic comp, pump, heat, save_m, refused, frost, flow, cond;
	logic [7:0] fan_o;
	int errors, total_checks, cyc, t0;
	csc_row_type rows [6];

	csc_plant plant_u (.clk_i(clk_i), .want_c_i(want_c), .want_t_i(want_t), .c_o(pin_c), .t_o(pin_t));
	csc_ctrl #(.TICK_DIV(4)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .remote_function_select_switch_i(sel),
		.remote_shutdown_i(pin_c.remote_shutdown), .remote_mode_i(pin_c.remote_mode),
		.flow_fault_i(pin_c.flow_fault), .overcurrent_i(pin_c.overcurrent), .wired_present_i(wpres),
		.wired_cmd_i(wcmd), .wired_run_i(wrun), .wired_mode_i(wmode), .panel_cmd_i(pcmd), .panel_run_i(prun),
		.panel_mode_i(pmode), .saved_mode_i(saved), .frost_reset_i(frst), .water_temp_i(pin_t.water),
		.outlet_temp_i(pin_t.outlet), .cond_temp_i(pin_t.condenser), .fan_pressure_i(fan),
		.compressor_o(comp), .pump_o(pump), .fan_speed_o(fan_o), .mode_heat_o(heat), .save_mode_o(save_m),
		.panel_refused_o(refused), .frost_alarm_o(frost), .flow_alarm_o(flow), .cond_alarm_o(cond));

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// cycles since reset release, for the start delay checks
	always @(posedge clk_i) cyc <= rst_n_i ? cyc + 1 : 0;

	task step(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	function logic pick(input int s);
		case (s)
			0: return comp;
			1: return pump;
			2: return frost;
			3: return flow;
			default: return cond;
		endcase
	endfunction
	// bounded wait; the caller compares afterwards
	task waitv(input int s, input logic v, input int lim);
		int k;
		k = 0;
		#1;
		while (pick(s) !== v && k < lim) begin
			@(posedge clk_i);
			#1;
			k++;
		end
	endtask
	task panel_go(input logic r, input logic m);
		step(1);
		prun <= r;
		pmode <= m;
		pcmd <= 1'b1;
		step(1);
		pcmd <= 1'b0;
	endtask
	task frost_pulse;
		step(1);
		frst <= 1'b1;
		step(1);
		frst <= 1'b0;
	endtask
	task test_done;
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog: the whole run needs about 4900 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		test_done;
	end

	initial begin
		rows[0] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h10, 1'b1, 1'b0};
		rows[1] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h80, 1'b0, 1'b0};
		rows[2] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'hff, 1'b0, 1'b1};
		rows[3] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h3c, 1'b1, 1'b0};
		rows[4] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h01, 1'b0, 1'b1};
		rows[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0};
		{sel, wpres, wcmd, wrun, wmode, pcmd, prun, pmode, saved, frst} = '0;
		errors = 0;
		total_checks = 0;
		fan = 8'h00;
		want_c = '0;
		want_t = '{8'sh0a, 8'sh14, 8'sh1e};
		rst_n_i = 1'b0;
		step(3);
		#1;
		`CHK({pump, comp, frost, flow, cond, heat, fan_o}, 14'h2000, "reset state")
		step(3);
		rst_n_i <= 1'b1;
		step(2);
		#1;
		`CHK(heat, 1'b0, "mode not restored")
		step(1);
		want_c.flow_fault <= 1'b1;
		step(100);
		#1;
		`CHK(flow, 1'b0, "flow alarm not masked")
		step(1);
		want_c.flow_fault <= 1'b0;
		$display("test reset done");

		// command arbitration and fan rows
		foreach (rows[i]) begin
			step(1);
			{wpres, wcmd, wmode, pcmd, pmode} <= {rows[i].pres, rows[i].wcmd, rows[i].wmode, rows[i].pcmd, rows[i].pmode};
			fan <= rows[i].fan;
			#1;
			`CHK(refused, rows[i].refused, "panel refusal")
			step(1);
			{wcmd, pcmd} <= 2'b00;
			#1;
			`CHK({heat, save_m}, {2{rows[i].heat}}, "mode after command")
			`CHK(fan_o, rows[i].fan, "fan speed")
		end
		$display("test command rows done");
		step(1);

		// remote mode contact: ignored while disabled, then forces mode on each change
		wpres <= 1'b0;
		want_c.remote_mode <= 1'b1;
		step(8);
		#1;
		`CHK(heat, 1'b0, "remote mode while disabled")
		step(1);
		sel <= 1'b1;
		want_c.remote_mode <= 1'b0;
		step(8);
		want_c.remote_mode <= 1'b1;
		step(8);
		#1;
		`CHK(heat, 1'b1, "remote heat")
		step(1);
		want_c.remote_mode <= 1'b0;
		step(8);
		#1;
		`CHK(heat, 1'b0, "remote cool")
		panel_go(1'b0, 1'b1);
		step(2);
		#1;
		`CHK(heat, 1'b1, "latest panel command")
		step(1);
		want_c.remote_mode <= 1'b1;
		step(8);
		want_c.remote_mode <= 1'b0;
		step(8);
		#1;
		`CHK(heat, 1'b0, "latest remote command")
		$display("test remote mode done");

		// cooling start waits for the pump lead
		panel_go(1'b1, 1'b0);
		want_t.water <= 8'sh0d;
		while (cyc < 1100) step(1);
		#1;
		`CHK(comp, 1'b0, "start before pump lead")
		waitv(0, 1'b1, 400);
		t0 = cyc;
		`CHK(comp, 1'b1, "cooling start")
		`CHK(cyc >= 1140, 1'b1, "pump lead too short")
		step(1);
		want_t.water <= 8'sh09;
		step(10);
		#1;
		`CHK(comp, 1'b1, "stop at 9")
		step(1);
		want_t.water <= 8'sh08;
		waitv(0, 1'b0, 10);
		`CHK(comp, 1'b0, "no stop below 9")
		step(1);
		want_t.water <= 8'sh0c;
		step(10);
		#1;
		`CHK(comp, 1'b0, "start at 12")
		step(1);
		want_t.water <= 8'sh0d;
		waitv(0, 1'b1, 1300);
		`CHK(comp, 1'b1, "no restart")
		`CHK(cyc - t0 >= 1200, 1'b1, "restart too soon")
		$display("test cooling done");

		// frost alarm and its manual reset
		step(1);
		want_t.outlet <= 8'sh02;
		waitv(2, 1'b1, 10);
		step(1);
		#1;
		`CHK({frost, comp, pump}, 3'b101, "frost trip")
		step(1);
		want_t.outlet <= 8'sh0f;
		frost_pulse;
		step(3);
		#1;
		`CHK(frost, 1'b1, "frost cleared at 15")
		step(1);
		want_t.outlet <= 8'sh10;
		step(10);
		#1;
		`CHK(frost, 1'b1, "frost cleared without reset")
		frost_pulse;
		step(2);
		#1;
		`CHK(frost, 1'b0, "frost not cleared")
		$display("test frost done");

		// flow alarm and its 15 s release
		step(1);
		want_c.flow_fault <= 1'b1;
		waitv(3, 1'b1, 10);
		step(1);
		#1;
		`CHK({flow, comp, pump}, 3'b101, "flow trip")
		step(1);
		want_c.flow_fault <= 1'b0;
		step(50);
		#1;
		`CHK(flow, 1'b1, "flow cleared early")
		waitv(3, 1'b0, 40);
		`CHK(flow, 1'b0, "flow not cleared")
		$display("test flow done");

		// condenser trip needs overcurrent and above 62
		step(1);
		want_c.overcurrent <= 1'b1;
		want_t.condenser <= 8'sh3e;
		step(10);
		#1;
		`CHK(cond, 1'b0, "condenser trip at 62")
		step(1);
		want_t.condenser <= 8'sh3f;
		waitv(4, 1'b1, 10);
		`CHK({cond, comp}, 2'b10, "condenser trip")
		step(1);
		want_c.overcurrent <= 1'b0;
		want_t.condenser <= 8'sh34;
		step(10);
		#1;
		`CHK(cond, 1'b1, "condenser clear at 52")
		step(1);
		want_t.condenser <= 8'sh33;
		waitv(4, 1'b0, 10);
		`CHK(cond, 1'b0, "condenser not cleared")
		$display("test condenser done");

		// heating thresholds
		panel_go(1'b1, 1'b1);
		want_t.water <= 8'sh2b;
		waitv(0, 1'b0, 10);
		`CHK(comp, 1'b0, "heating above 42")
		step(1);
		want_t.water <= 8'sh26;
		step(10);
		#1;
		`CHK(comp, 1'b0, "heating start at 38")
		step(1);
		want_t.water <= 8'sh25;
		waitv(0, 1'b1, 1300);
		`CHK(comp, 1'b1, "heating start")
		step(1);
		want_t.water <= 8'sh2a;
		step(10);
		#1;
		`CHK(comp, 1'b1, "heating stop at 42")
		$display("test heating done");

		// remote shutdown: stop, pump run-on, protections live
		step(1);
		want_c.remote_shutdown <= 1'b1;
		waitv(0, 1'b0, 10);
		`CHK(comp, 1'b0, "shutdown stop")
		step(440);
		#1;
		`CHK(pump, 1'b1, "pump run-on short")
		waitv(1, 1'b0, 100);
		`CHK(pump, 1'b0, "pump run-on long")
		panel_go(1'b1, 1'b1);
		want_t.water <= 8'sh25;
		step(800);
		#1;
		`CHK(comp, 1'b0, "start during shutdown")
		step(1);
		want_t.outlet <= 8'sh02;
		waitv(2, 1'b1, 10);
		`CHK(frost, 1'b1, "frost during shutdown")
		$display("test shutdown done");

		// second reset restores the stored mode
		step(1);
		saved <= 1'b1;
		rst_n_i <= 1'b0;
		step(6);
		#1;
		`CHK({pump, comp, frost}, 3'b100, "second reset")
		step(1);
		rst_n_i <= 1'b1;
		step(2);
		#1;
		`CHK(heat, 1'b1, "stored mode")
		$display("test second reset done");
		test_done;
	end
endmodule
